// ---- arc_defines.vh ----
// constants for the converter result coding block
`ifndef ARC_DEFINES_VH
`define ARC_DEFINES_VH
// ----------------------------------------
// channel numbers on the multiplexer
// ----------------------------------------
`define ARC_NUM_CH        9
`define ARC_CH_W          4
`define ARC_CH_UNCOMMITTED_INPUT_ZERO  4'h0
`define ARC_CH_UNCOMMITTED_INPUT_ONE   4'h1
`define ARC_CH_UNCOMMITTED_INPUT_TWO   4'h2
`define ARC_CH_UNCOMMITTED_INPUT_THREE 4'h3
`define ARC_CH_ISNS1      4'h4
`define ARC_CH_ISNS2      4'h5
`define ARC_CH_TEMP_LOC   4'h6
`define ARC_CH_TEMP_R1    4'h7
`define ARC_CH_TEMP_R2    4'h8
// ----------------------------------------
// result coding
// ----------------------------------------
`define ARC_RES_W         12
`define ARC_CODES         4096
`define ARC_LSB_SHIFT_W   3
// lsb weight as multiple of vref/4096
`define ARC_WT_1X         3'h1
`define ARC_WT_2X         3'h2
`define ARC_WT_4X         3'h4
// current sense amplifier gain, tenths
`define ARC_ISNS_GAIN_X10 8'h7d
`define ARC_RES_RST       12'h000
`define ARC_CH_RST        4'h0
`endif

// ---- arc_format.v ----
// per-channel code formatter: raw sar code to result coding
module arc_format
#(
  parameter RES_W = 12
)
(
  input  wire [RES_W-1:0] raw_code,
  input  wire             twos_mode,
  output wire [RES_W-1:0] fmt_code
);
  // ----------------------------------------
  // offset binary to twos complement
  // ----------------------------------------
  // flipping msb maps midscale to zero, 0x7ff top, 0x800 bottom
  assign fmt_code = twos_mode ? {~raw_code[RES_W-1], raw_code[RES_W-2:0]} : raw_code;
endmodule

// ---- arc_core.v ----
// result coding and channel configuration for the 12-bit converter
`include "arc_defines.vh"
// How it works
// - nine channels selected by one mux into the single converter
// - internal reference disable steers the external reference select output
// - single-ended step weight is 1x vref/4096 low range, 2x doubled
// - differential step weight is 2x vref/4096 low range, 4x doubled
// - single-ended uncommitted inputs output straight binary 0x000..0xfff
// - differential pairs output twos complement 0x800..0x7ff
// - current sense results twos complement, zero input gives zero code
// - temperature results twos complement, quarter degree per step
// - pseudo differential pairs fixed: inputs zero/one and two/three
// - pseudo differential results stored twos complement like differential
module arc_core
#(
  parameter NUM_CH = `ARC_NUM_CH,
  parameter RES_W  = `ARC_RES_W
)
(
  input  wire              sys_clk,
  input  wire              rst_n,
  input  wire [3:0]        ch_select,
  input  wire              conv_start,
  input  wire              conv_done,
  input  wire [RES_W-1:0]  raw_code,
  input  wire              pair01_diff,
  input  wire              pair23_diff,
  input  wire              range_double,
  input  wire              int_ref_off,
  output reg  [3:0]        mux_channel,
  output wire              ext_ref_sel,
  output reg  [RES_W-1:0]  result,
  output reg  [3:0]        result_channel,
  output reg               result_twos,
  output reg  [2:0]        lsb_weight,
  output reg               result_valid,
  output wire              busy
);
  // ----------------------------------------
  // state machine
  // ----------------------------------------
  localparam ST_IDLE = 2'b01;
  localparam ST_CONV = 2'b10;

  reg  [1:0]       state;
  reg  [1:0]       next_state;
  reg              lat_twos;
  reg              lat_diff;
  reg              lat_range;
  wire [RES_W-1:0] fmt_code;
  reg  [3:0]       next_mux_channel;
  reg              next_lat_twos;
  reg              next_lat_diff;
  reg              next_lat_range;
  reg  [RES_W-1:0] next_result;
  reg  [3:0]       next_result_channel;
  reg              next_result_twos;
  reg  [2:0]       next_lsb_weight;
  wire             take_start;
  wire             finish;

  // differential setting for an uncommitted channel, pairs fixed
  function chan_diff;
    input [3:0] ch;
    input       d01;
    input       d23;
    begin
      if (ch == `ARC_CH_UNCOMMITTED_INPUT_ZERO || ch == `ARC_CH_UNCOMMITTED_INPUT_ONE)
        chan_diff = d01;
      else if (ch == `ARC_CH_UNCOMMITTED_INPUT_TWO || ch == `ARC_CH_UNCOMMITTED_INPUT_THREE)
        chan_diff = d23;
      else
        chan_diff = 1'b0;
    end
  endfunction

  // twos complement for bipolar channels or differential pairs
  function chan_twos;
    input [3:0] ch;
    input       d01;
    input       d23;
    begin
      if (ch >= `ARC_CH_ISNS1 && ch <= `ARC_CH_TEMP_R2)
        chan_twos = 1'b1;
      else
        chan_twos = chan_diff(ch, d01, d23);
    end
  endfunction

  // step weight in units of vref/4096: doubled range and differential each double it
  function [2:0] step_weight;
    input diff;
    input dbl;
    begin
      case ({diff, dbl})
        2'b00:   step_weight = `ARC_WT_1X;
        2'b01:   step_weight = `ARC_WT_2X;
        2'b10:   step_weight = `ARC_WT_2X;
        2'b11:   step_weight = `ARC_WT_4X;
        default: step_weight = `ARC_WT_1X;
      endcase
    end
  endfunction

  // reference select follows the disable bit
  assign ext_ref_sel = int_ref_off;
  assign busy        = state[1];

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always @*
  begin
    next_state = state;
    case (state)
      ST_IDLE:
      begin
        if (conv_start && ch_select < NUM_CH)
          next_state = ST_CONV;
      end
      ST_CONV:
      begin
        if (conv_done)
          next_state = ST_IDLE;
      end
      default:
        next_state = ST_IDLE;
    endcase
  end

  // ----------------------------------------
  // start and finish strobes
  // ----------------------------------------
  // a start is taken only from idle with a channel that exists
  assign take_start = (state == ST_IDLE) && (next_state == ST_CONV);
  // done outside a conversion is ignored
  assign finish     = (state == ST_CONV) && conv_done;

  // ----------------------------------------
  // next values of the latched settings
  // ----------------------------------------
  // mode sampled once at start so later changes cannot skew the result
  always @*
  begin
    next_mux_channel = mux_channel;
    next_lat_twos    = lat_twos;
    next_lat_diff    = lat_diff;
    next_lat_range   = lat_range;
    if (take_start)
    begin
      next_mux_channel = ch_select;
      next_lat_twos    = chan_twos(ch_select, pair01_diff, pair23_diff);
      next_lat_diff    = chan_diff(ch_select, pair01_diff, pair23_diff);
      next_lat_range   = range_double;
    end
  end

  // ----------------------------------------
  // next values of the result fields
  // ----------------------------------------
  // result fields hold until the next finished conversion
  always @*
  begin
    next_result         = result;
    next_result_channel = result_channel;
    next_result_twos    = result_twos;
    next_lsb_weight     = lsb_weight;
    if (finish)
    begin
      next_result         = fmt_code;
      next_result_channel = mux_channel;
      next_result_twos    = lat_twos;
      next_lsb_weight     = step_weight(lat_diff, lat_range);
    end
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      state <= ST_IDLE;
    else
      state <= next_state;
  end

  // ----------------------------------------
  // latched settings
  // ----------------------------------------
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mux_channel <= `ARC_CH_RST;
      lat_twos    <= 1'b0;
      lat_diff    <= 1'b0;
      lat_range   <= 1'b0;
    end
    else
    begin
      mux_channel <= next_mux_channel;
      lat_twos    <= next_lat_twos;
      lat_diff    <= next_lat_diff;
      lat_range   <= next_lat_range;
    end
  end

  // ----------------------------------------
  // result registers
  // ----------------------------------------
  // valid is a one-cycle strobe on each finished conversion
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      result         <= `ARC_RES_RST;
      result_channel <= `ARC_CH_RST;
      result_twos    <= 1'b0;
      lsb_weight     <= `ARC_WT_1X;
      result_valid   <= 1'b0;
    end
    else
    begin
      result         <= next_result;
      result_channel <= next_result_channel;
      result_twos    <= next_result_twos;
      lsb_weight     <= next_lsb_weight;
      result_valid   <= finish;
    end
  end

  // formatter applies the latched coding
  arc_format #(.RES_W(RES_W)) arc_format_inst
  (
    .raw_code  (raw_code),
    .twos_mode (lat_twos),
    .fmt_code  (fmt_code)
  );
endmodule

// ---- arc_core_asserts.sv ----
// concurrent checks on the result coding core ports
module arc_core_asserts (
  input wire logic        sys_clk,
  input wire logic        rst_n,
  input wire logic [3:0]  ch_select,
  input wire logic        conv_start,
  input wire logic        conv_done,
  input wire logic [11:0] raw_code,
  input wire logic        pair01_diff,
  input wire logic        pair23_diff,
  input wire logic        range_double,
  input wire logic        int_ref_off,
  input wire logic [3:0]  mux_channel,
  input wire logic        ext_ref_sel,
  input wire logic [11:0] result,
  input wire logic [3:0]  result_channel,
  input wire logic        result_twos,
  input wire logic [2:0]  lsb_weight,
  input wire logic        result_valid,
  input wire logic        busy
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // ----------------------------------------
  // mode and weight captured at an accepted start
  // ----------------------------------------
  wire       take = conv_start && !busy && ch_select < 4'h9;
  wire       diff = ch_select[1] ? pair23_diff : pair01_diff;
  logic       exp_twos;
  logic [2:0] exp_wt;
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      exp_twos <= 1'b0;
      exp_wt   <= 3'h1;
    end
    else if (take)
    begin
      exp_twos <= ch_select > 4'h3 || diff;
      exp_wt   <= {1'b0, diff, !diff} << range_double;
    end
  end
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  AST_MUX: assert property (take |=> busy && mux_channel == $past(ch_select)) else $error("bad mux latch");
  AST_REFUSE: assert property (conv_start && !busy && ch_select > 4'h8 |=> !busy) else $error("bad channel taken");
  AST_VALID: assert property (busy && conv_done |=> result_valid && result_channel == mux_channel) else $error("no result");
  AST_PULSE: assert property (result_valid |=> !result_valid) else $error("valid too long");
  AST_REF: assert property (ext_ref_sel == int_ref_off) else $error("ref select wrong");
  AST_WT: assert property (result_valid && result_channel < 4'h4 |-> lsb_weight == exp_wt) else $error("bad weight");
  AST_CODE: assert property (result_valid |-> result == ($past(raw_code) ^ {result_twos, 11'h000})) else $error("bad code");
  AST_MODE: assert property (result_valid |-> result_twos == exp_twos) else $error("bad format");
  // main scenarios
  cover property (result_valid && result_twos);
  cover property (result_valid && !result_twos);
  cover property (conv_start && busy);
endmodule

// ---- test_adc_result_coding.sv ----
// testbench for the result coding core
module test_adc_result_coding;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic        sys_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        conv_start = 1'b0;
  logic        conv_done = 1'b0;
  logic        int_ref_off = 1'b0;
  logic        pair01_diff = 1'b0;
  logic        pair23_diff = 1'b0;
  logic        range_double = 1'b0;
  logic [3:0]  ch_select = 4'h0;
  logic [11:0] raw_code = 12'h000;
  logic        ext_ref_sel;
  logic        result_twos;
  logic        result_valid;
  logic        busy;
  logic [3:0]  mux_channel;
  logic [3:0]  result_channel;
  logic [11:0] result;
  logic [2:0]  lsb_weight;
  logic [11:0] raws [4] = '{12'hfff, 12'h000, 12'h800, 12'h7ff};
  logic        tw;
  int          fail_count = 0;
  int          n_compared = 0;

  // clock, 20 ns period
  always #10 sys_clk = ~sys_clk;

  // device under test
  arc_core arc_core_inst
  (
    .sys_clk        (sys_clk),
    .rst_n          (rst_n),
    .ch_select      (ch_select),
    .conv_start     (conv_start),
    .conv_done      (conv_done),
    .raw_code       (raw_code),
    .pair01_diff    (pair01_diff),
    .pair23_diff    (pair23_diff),
    .range_double   (range_double),
    .int_ref_off    (int_ref_off),
    .mux_channel    (mux_channel),
    .ext_ref_sel    (ext_ref_sel),
    .result         (result),
    .result_channel (result_channel),
    .result_twos    (result_twos),
    .lsb_weight     (lsb_weight),
    .result_valid   (result_valid),
    .busy           (busy)
  );

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  // compare one value
  task chk(input logic [11:0] seen, input logic [11:0] expd);
    n_compared++;
    if (seen !== expd)
    begin
      fail_count++;
      $display("[FAIL] %0t got %h want %h", $time, seen, expd);
    end
  endtask

  // one conversion; pair modes flip mid-conversion and must not matter
  task conv(input logic [3:0] ch, input logic [11:0] raw, input logic [1:0] p, input logic rng);
    @(posedge sys_clk);
    {ch_select, pair23_diff, pair01_diff, range_double, conv_start} <= {ch, p, rng, 1'b1};
    @(posedge sys_clk);
    {conv_start, pair23_diff, pair01_diff, conv_done, raw_code} <= {1'b0, ~p, 1'b1, raw};
    #1;
    chk({11'h000, busy}, 12'h001);
    chk({8'h00, mux_channel}, {8'h00, ch});
    @(posedge sys_clk);
    conv_done <= 1'b0;
    #1;
  endtask

  // report counts and the verdict, then stop
  task print_verdict;
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // ----------------------------------------
  // watchdog and test sequence
  // ----------------------------------------
  // a hang counts as a mismatch
  initial
  begin
    #20000;
    fail_count++;
    print_verdict;
  end

  // reset, all channels (all four modes on channels two and three), start while busy, refusal
  initial
  begin
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    #1;
    chk({9'h000, lsb_weight}, 12'h001);
    chk({11'h000, result_valid}, 12'h000);
    chk({11'h000, ext_ref_sel}, 12'h000);
    for (int c = 0; c < 9; c++)
    begin
      for (int p = 0; p < 4; p++)
      begin
        conv(c[3:0], raws[p], p[1:0], c[0] ^ p[0]);
        tw = c > 3 || (c > 1 ? p[1] : p[0]);
        chk({11'h000, result_valid}, 12'h001);
        chk({8'h00, result_channel}, c[11:0]);
        chk(result, raws[p] ^ {tw, 11'h000});
        chk({11'h000, result_twos}, {11'h000, tw});
        if (c < 4)
          chk({9'h000, lsb_weight}, (tw ? 12'h002 : 12'h001) << (c[0] ^ p[0]));
      end
    end
    $display("test done: formats");
    @(posedge sys_clk);
    {ch_select, conv_start} <= {4'h6, 1'b1};
    @(posedge sys_clk);
    ch_select <= 4'h2;
    @(posedge sys_clk);
    {conv_start, conv_done, raw_code} <= {1'b0, 1'b1, 12'h123};
    @(posedge sys_clk);
    conv_done <= 1'b0;
    #1;
    chk({11'h000, result_valid}, 12'h001);
    chk({8'h00, result_channel}, 12'h006);
    chk(result, 12'h923);
    $display("test done: start while busy");
    @(posedge sys_clk);
    {ch_select, conv_start, int_ref_off} <= {4'h9, 1'b1, 1'b1};
    @(posedge sys_clk);
    conv_start <= 1'b0;
    #1;
    chk({11'h000, busy}, 12'h000);
    chk({11'h000, ext_ref_sel}, 12'h001);
    $display("test done: refusal and reference");
    print_verdict;
  end
endmodule
bind arc_core arc_core_asserts arc_core_asserts_inst
(
  .sys_clk        (sys_clk),
  .rst_n          (rst_n),
  .ch_select      (ch_select),
  .conv_start     (conv_start),
  .conv_done      (conv_done),
  .raw_code       (raw_code),
  .pair01_diff    (pair01_diff),
  .pair23_diff    (pair23_diff),
  .range_double   (range_double),
  .int_ref_off    (int_ref_off),
  .mux_channel    (mux_channel),
  .ext_ref_sel    (ext_ref_sel),
  .result         (result),
  .result_channel (result_channel),
  .result_twos    (result_twos),
  .lsb_weight     (lsb_weight),
  .result_valid   (result_valid),
  .busy           (busy)
);
